//--- design/uart_mode_pkg.sv
// Shared constants for the channel mode block: register indices, fields, reset values
package uart_mode_pkg;

	// Register word indices; the byte address is four times the index
	localparam logic [5:0] IDX_PTR = 6'h00;
	localparam logic [5:0] IDX_MODE1 = 6'h21;
	localparam logic [5:0] IDX_CMC = 6'h22;
	localparam logic [5:0] IDX_ENABLE = 6'h30;
	localparam logic [5:0] IDX_STATUS = 6'h31;
	localparam logic [5:0] IDX_RXDATA = 6'h32;
	localparam logic [5:0] IDX_TXDATA = 6'h33;
	localparam logic [5:0] IDX_DIV_LO = 6'h34;
	localparam logic [5:0] IDX_DIV_HI = 6'h35;

	// channel_mode_control field
	localparam int CMC_MODE_HI = 7;
	localparam int CMC_MODE_LO = 6;
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_ECHO = 2'h1;
	localparam logic [1:0] MODE_LOCAL = 2'h2;
	localparam logic [1:0] MODE_REMOTE = 2'h3;

	// Character format byte reached through the pointer window
	localparam int M1_PAR_OFF = 4;
	localparam int M1_ODD = 2;

	// Enable register fields
	localparam int EN_RX = 0;
	localparam int EN_TX = 1;
	localparam int EN_PTR_RST = 4;

	// Status register fields
	localparam int ST_RX_RDY = 0;
	localparam int ST_SPACE = 2;
	localparam int ST_TX_IDLE = 3;
	localparam int ST_OVR = 4;
	localparam int ST_PERR = 5;
	localparam int ST_FERR = 6;
	localparam int ST_BRK = 7;

	// Reset values
	localparam logic [7:0] RST_CMC = 8'h00;
	localparam logic [7:0] RST_MODE1 = 8'h13;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [15:0] RST_DIV = 16'h0040;

	localparam logic [2:0] LAST_DATA_BIT = 3'h7;

endpackage

//--- design/bit_tick_gen.sv
// Bit-rate divider giving a one-cycle tick per bit time, with phase restart
`timescale 1ns/100ps
module bit_tick_gen (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic restart_i, // Reload to half a bit time
	input wire logic [15:0] divisor_i, // Clock cycles per bit
	output logic tick_o // One-cycle bit strobe
);
	typedef struct packed {
		logic [15:0] cnt;
	} div_s;

	div_s st_r;
	div_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (restart_i) begin
			// Half a bit lands the next tick in the middle of the start bit
			st_nxt.cnt = {1'b0, divisor_i[15:1]};
		end else if (st_r.cnt == 16'h0000) begin
			st_nxt.cnt = divisor_i - 16'h0001;
		end else begin
			st_nxt.cnt = st_r.cnt - 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick_o = (st_r.cnt == 16'h0000);

endmodule

//--- design/uart_channel_mode.sv
// Serial channel with normal, echo, local loopback and remote loopback modes
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
module uart_channel_mode (
	input wire logic clk_i, // 10 MHz system clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic rxd_i, // Serial input pin
	output logic txd_o // Serial output pin
);
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;
	typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_PAR, TX_STOP} tx_state_e;

	typedef struct packed {
		logic [2:0] sync;
		logic line;
		logic [7:0] mode1;
		logic [7:0] cmc;
		logic [7:0] en;
		logic [15:0] div;
		logic ptr;
		logic ack;
		logic [7:0] rdat;
		rx_state_e rx_st;
		logic [2:0] rx_cnt;
		logic [7:0] rx_sh;
		logic rx_pbit;
		logic rx_prev;
		logic [7:0] rx_data;
		logic rx_rdy;
		logic ovr;
		logic perr;
		logic ferr;
		logic brk;
		logic echo;
		tx_state_e tx_st;
		logic [2:0] tx_cnt;
		logic [7:0] tx_sh;
		logic [7:0] tx_hold;
		logic tx_pbit;
		logic tx_full;
		logic tx_line;
		logic pin;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	logic req;
	logic commit;
	logic wr;
	logic rd;
	logic [5:0] idx;
	logic [5:0] eidx;
	logic [1:0] mode;
	logic rx_en;
	logic tx_en;
	logic par_en;
	logic odd;
	logic rx_on;
	logic rx_in;
	logic rxt;
	logic rx_restart;
	logic rx_tick;
	logic tx_tick;
	logic remote;
	logic echo_md;
	logic [7:0] status;
	logic frame_bad;

	// Resolves the legacy pointer window onto the register it currently selects
	function automatic logic [5:0] eff_idx(input logic [5:0] a, input logic p);
		if (a == uart_mode_pkg::IDX_PTR) begin
			eff_idx = p ? uart_mode_pkg::IDX_CMC : uart_mode_pkg::IDX_MODE1;
		end else begin
			eff_idx = a;
		end
	endfunction

	bit_tick_gen rx_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(rx_restart),
		.divisor_i(st_r.div),
		.tick_o(rx_tick)
	);

	bit_tick_gen tx_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(1'b0),
		.divisor_i(st_r.div),
		.tick_o(tx_tick)
	);

	assign idx = wb_adr_i[7:2];
	assign eidx = eff_idx(idx, st_r.ptr);
	assign req = wb_cyc_i & wb_stb_i;
	// Writes and read side effects land on the edge where the master sees ack
	assign commit = req & st_r.ack;
	assign wr = commit & wb_we_i & wb_sel_i[0];
	assign rd = commit & ~wb_we_i;

	assign mode = st_r.cmc[uart_mode_pkg::CMC_MODE_HI:uart_mode_pkg::CMC_MODE_LO];
	assign remote = (mode == uart_mode_pkg::MODE_REMOTE);
	assign echo_md = (mode == uart_mode_pkg::MODE_ECHO);
	assign rx_en = st_r.en[uart_mode_pkg::EN_RX];
	assign tx_en = st_r.en[uart_mode_pkg::EN_TX];
	assign par_en = ~st_r.mode1[uart_mode_pkg::M1_PAR_OFF];
	assign odd = st_r.mode1[uart_mode_pkg::M1_ODD];

	// Local loop is gated by the transmitter enable, every other mode by the receiver
	assign rx_on = (mode == uart_mode_pkg::MODE_LOCAL) ? tx_en : rx_en;
	// Local loop takes the transmitter line and drops the pin
	assign rx_in = (mode == uart_mode_pkg::MODE_LOCAL) ? st_r.tx_line : st_r.line;
	assign rxt = (mode == uart_mode_pkg::MODE_LOCAL) ? tx_tick : rx_tick;
	assign frame_bad = ~rx_in;

	always_comb begin
		status = 8'h00;
		status[uart_mode_pkg::ST_RX_RDY] = st_r.rx_rdy & ~remote;
		status[uart_mode_pkg::ST_SPACE] = ~st_r.tx_full & ~echo_md;
		status[uart_mode_pkg::ST_TX_IDLE] = ~st_r.tx_full & (st_r.tx_st == TX_IDLE) & ~echo_md;
		status[uart_mode_pkg::ST_OVR] = st_r.ovr & ~remote;
		status[uart_mode_pkg::ST_PERR] = st_r.perr & ~remote;
		status[uart_mode_pkg::ST_FERR] = st_r.ferr & ~remote;
		status[uart_mode_pkg::ST_BRK] = st_r.brk & ~remote;
	end

	always_comb begin
		st_nxt = st_r;
		rx_restart = 1'b0;

		// Pin synchroniser: the filtered level moves only when stages two and three agree
		st_nxt.sync = {st_r.sync[1:0], rxd_i};
		if (st_r.sync[1] == st_r.sync[2]) begin
			st_nxt.line = st_r.sync[2];
		end

		// Register slave: one wait state, then ack for exactly one cycle
		st_nxt.ack = req & ~st_r.ack;
		if (req & ~st_r.ack) begin
			case (eidx)
				uart_mode_pkg::IDX_MODE1: st_nxt.rdat = st_r.mode1;
				uart_mode_pkg::IDX_CMC: st_nxt.rdat = st_r.cmc;
				uart_mode_pkg::IDX_ENABLE: st_nxt.rdat = st_r.en;
				uart_mode_pkg::IDX_STATUS: st_nxt.rdat = status;
				uart_mode_pkg::IDX_RXDATA: st_nxt.rdat = st_r.rx_data;
				uart_mode_pkg::IDX_DIV_LO: st_nxt.rdat = st_r.div[7:0];
				uart_mode_pkg::IDX_DIV_HI: st_nxt.rdat = st_r.div[15:8];
				default: st_nxt.rdat = 8'h00;
			endcase
		end
		if (wr) begin
			case (eidx)
				uart_mode_pkg::IDX_MODE1: st_nxt.mode1 = wb_dat_i[7:0];
				uart_mode_pkg::IDX_CMC: st_nxt.cmc = wb_dat_i[7:0];
				uart_mode_pkg::IDX_ENABLE: begin
					st_nxt.en = {4'h0, wb_dat_i[3:0]};
					if (wb_dat_i[uart_mode_pkg::EN_PTR_RST]) begin
						st_nxt.ptr = 1'b0;
					end
				end
				uart_mode_pkg::IDX_TXDATA: begin
					// The host path to the transmitter is cut in echo mode
					if (~echo_md & ~st_r.tx_full) begin
						st_nxt.tx_hold = wb_dat_i[7:0];
						st_nxt.tx_full = 1'b1;
					end
				end
				uart_mode_pkg::IDX_DIV_LO: st_nxt.div[7:0] = wb_dat_i[7:0];
				uart_mode_pkg::IDX_DIV_HI: st_nxt.div[15:8] = wb_dat_i[7:0];
				default: st_nxt.rdat = st_r.rdat;
			endcase
		end
		// The window steps from the format byte to channel_mode_control after one access
		if (commit && idx == uart_mode_pkg::IDX_PTR) begin
			st_nxt.ptr = 1'b1;
		end
		if (rd && eidx == uart_mode_pkg::IDX_RXDATA) begin
			st_nxt.rx_rdy = 1'b0;
			st_nxt.ovr = 1'b0;
		end

		// Transmitter; it finishes a character already begun even if disabled
		if (tx_tick) begin
			case (st_r.tx_st)
				TX_IDLE: begin
					if (tx_en && st_r.tx_full) begin
						st_nxt.tx_line = 1'b0;
						st_nxt.tx_sh = st_r.tx_hold;
						st_nxt.tx_pbit = (^st_r.tx_hold) ^ odd;
						st_nxt.tx_full = 1'b0;
						st_nxt.tx_cnt = 3'h0;
						st_nxt.tx_st = TX_DATA;
					end
				end
				TX_DATA: begin
					st_nxt.tx_line = st_r.tx_sh[0];
					st_nxt.tx_sh = {1'b0, st_r.tx_sh[7:1]};
					st_nxt.tx_cnt = st_r.tx_cnt + 3'h1;
					if (st_r.tx_cnt == uart_mode_pkg::LAST_DATA_BIT) begin
						st_nxt.tx_st = par_en ? TX_PAR : TX_STOP;
					end
				end
				TX_PAR: begin
					st_nxt.tx_line = st_r.tx_pbit;
					st_nxt.tx_st = TX_STOP;
				end
				TX_STOP: begin
					st_nxt.tx_line = 1'b1;
					st_nxt.tx_st = TX_IDLE;
				end
				default: st_nxt.tx_st = TX_IDLE;
			endcase
		end

		// Receiver; every sampled bit is also copied to the echo line, except the start bit in local loop, which is sampled in RX_IDLE
		st_nxt.rx_prev = rx_in;
		case (st_r.rx_st)
			RX_IDLE: begin
				// Break stays low until mark; the next start then waits for its mid-bit sample
				st_nxt.echo = st_r.brk ? (rx_in | st_r.echo) : 1'b1;
				if (rx_on) begin
					if (mode == uart_mode_pkg::MODE_LOCAL) begin
						if (rxt && !rx_in) begin
							st_nxt.rx_cnt = 3'h0;
							st_nxt.rx_st = RX_DATA;
						end
					end else if (st_r.rx_prev && !rx_in) begin
						rx_restart = 1'b1;
						st_nxt.rx_st = RX_START;
					end
				end
			end
			RX_START: begin
				if (rxt) begin
					if (!rx_in) begin
						st_nxt.echo = 1'b0;
						st_nxt.brk = 1'b0;
						st_nxt.rx_cnt = 3'h0;
						st_nxt.rx_st = RX_DATA;
					end else begin
						st_nxt.rx_st = RX_IDLE;
					end
				end
			end
			RX_DATA: begin
				if (rxt) begin
					st_nxt.echo = rx_in;
					st_nxt.rx_sh = {rx_in, st_r.rx_sh[7:1]};
					st_nxt.rx_cnt = st_r.rx_cnt + 3'h1;
					if (st_r.rx_cnt == uart_mode_pkg::LAST_DATA_BIT) begin
						st_nxt.rx_st = par_en ? RX_PAR : RX_STOP;
					end
				end
			end
			RX_PAR: begin
				if (rxt) begin
					// Parity goes out as received, never recomputed
					st_nxt.echo = rx_in;
					st_nxt.rx_pbit = rx_in;
					st_nxt.rx_st = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rxt) begin
					st_nxt.echo = rx_in;
					st_nxt.rx_st = RX_IDLE;
					if (frame_bad && st_r.rx_sh == 8'h00 && !(par_en && st_r.rx_pbit)) begin
						st_nxt.brk = 1'b1;
					end
					// Remote loop keeps the character and its errors from the host
					if (!remote) begin
						st_nxt.rx_data = st_r.rx_sh;
						st_nxt.ovr = st_nxt.ovr | st_nxt.rx_rdy;
						st_nxt.rx_rdy = 1'b1;
						st_nxt.perr = par_en & (st_r.rx_pbit != ((^st_r.rx_sh) ^ odd));
						st_nxt.ferr = frame_bad;
					end
				end
			end
			default: st_nxt.rx_st = RX_IDLE;
		endcase
		if (!rx_on) begin
			st_nxt.rx_st = RX_IDLE;
		end

		// Output pin steering per mode
		case (mode)
			uart_mode_pkg::MODE_NORMAL: st_nxt.pin = st_r.tx_line;
			uart_mode_pkg::MODE_ECHO: st_nxt.pin = rx_en ? st_r.echo : 1'b1;
			uart_mode_pkg::MODE_LOCAL: st_nxt.pin = 1'b1;
			uart_mode_pkg::MODE_REMOTE: st_nxt.pin = rx_en ? st_r.echo : 1'b1;
			default: st_nxt.pin = 1'b1;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.sync <= 3'h7;
			st_r.line <= 1'b1;
			st_r.rx_prev <= 1'b1;
			st_r.mode1 <= uart_mode_pkg::RST_MODE1;
			st_r.cmc <= uart_mode_pkg::RST_CMC;
			st_r.en <= uart_mode_pkg::RST_ENABLE;
			st_r.div <= uart_mode_pkg::RST_DIV;
			st_r.echo <= 1'b1;
			st_r.tx_line <= 1'b1;
			st_r.pin <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign txd_o = st_r.pin;
	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = {24'h000000, st_r.rdat};

endmodule

//--- verification/uart_mode_monitor.sv
// Port checker for the channel mode block
`timescale 1ns/100ps
module uart_mode_monitor (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic [7:0] wb_adr_i, // Address
	input wire logic [3:0] wb_sel_i, // Selects
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Ack
	input wire logic rxd_i, // Serial in
	input wire logic txd_o // Serial out
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [1:0] mode_r;
	logic [1:0] mode_nxt;
	logic rd;
	logic [5:0] idx;
	assign idx = wb_adr_i[7:2];
	assign rd = wb_ack_o && !wb_we_i;
	// Only direct writes are tracked; the bench never writes the mode through the window
	always_comb begin
		mode_nxt = mode_r;
		if (wb_ack_o && wb_we_i && wb_sel_i[0] && idx == uart_mode_pkg::IDX_CMC) begin
			mode_nxt = wb_dat_i[7:6];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r <= 2'h0;
		end else begin
			mode_r <= mode_nxt;
		end
	end
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ans_s;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	chk_ack_once: assert property (req_s |=> ans_s)
		else $error("ack late or held");
	chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_upper_zero: assert property (rd |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_mode_read: assert property (rd && idx == uart_mode_pkg::IDX_CMC |-> wb_dat_o[7:6] == mode_r)
		else $error("mode field readback wrong");
	chk_unmapped_read: assert property (rd && idx == 6'h3f |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_echo_status: assert property (rd && idx == uart_mode_pkg::IDX_STATUS
		&& mode_r == uart_mode_pkg::MODE_ECHO |-> wb_dat_o[3:2] == 2'h0)
		else $error("transmit flags active in echo");
	chk_remote_status: assert property (rd && idx == uart_mode_pkg::IDX_STATUS
		&& mode_r == uart_mode_pkg::MODE_REMOTE |-> {wb_dat_o[7:4], wb_dat_o[0]} == 5'h0)
		else $error("receive status active in remote loop");
	chk_local_high: assert property (mode_r == uart_mode_pkg::MODE_LOCAL
		&& $past(mode_r) == uart_mode_pkg::MODE_LOCAL |-> txd_o)
		else $error("output low in local loop");
endmodule
bind uart_channel_mode uart_mode_monitor i_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rxd_i, .txd_o);

//--- verification/serial_partner.sv
// Remote serial transceiver model on the line side
`timescale 1ns/100ps
module serial_partner #(
	parameter int BIT_CYC = 16
) (
	input wire logic clk_i, // Clock
	input wire logic line_i, // Device serial output
	output logic line_o // Device serial input
);
	logic [7:0] got_r;
	int unsigned got_count;
	initial begin
		line_o = 1'b1;
		got_r = 8'h0;
		got_count = 0;
	end
	// Start, eight data bits LSB first, one stop; the line rests at mark
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_o <= f[i];
			repeat (BIT_CYC) @(posedge clk_i);
		end
	endtask
	// Holds the line at one level, to start and end a break
	task automatic hold_line(input logic v);
		line_o <= v;
	endtask
	// Frames with a bad stop bit are not counted, so a break held past the stop sample never raises got_count
	always begin
		@(negedge line_i);
		repeat (BIT_CYC / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk_i);
			got_r[i] = line_i;
		end
		repeat (BIT_CYC) @(posedge clk_i);
		if (line_i === 1'b1) begin
			got_count++;
		end
	end
endmodule

//--- verification/tb.sv
// Self-checking bench for the channel mode block
`timescale 1ns/100ps
module tb;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rxd_i, txd_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	int bad_count = 0;
	int total_checks = 0;
	uart_channel_mode i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rxd_i, .txd_o);
	serial_partner #(.BIT_CYC(16)) i_peer (.clk_i, .line_i(txd_o), .line_o(rxd_i));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d,
		output logic [31:0] r);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {i, 2'h0};
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		chk(32'(n), 32'h2);
	endtask
	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		logic [31:0] r;
		wb(1'b1, i, d, r);
	endtask
	task automatic rd(input logic [5:0] i);
		wb(1'b0, i, 8'h0, q);
	endtask
	task automatic wait_rx;
		int n;
		n = 0;
		do begin
			rd(uart_mode_pkg::IDX_STATUS);
			n++;
		end while (q[0] !== 1'b1 && n < 100);
	endtask
	task automatic wait_echo(input int c);
		int n;
		n = 0;
		while (i_peer.got_count != c && n < 400) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic t_reset;
		rd(uart_mode_pkg::IDX_CMC);
		chk(q, 32'h0);
		chk({31'h0, txd_o}, 32'h1);
		rd(uart_mode_pkg::IDX_PTR);
		chk(q, {24'h0, uart_mode_pkg::RST_MODE1});
		wr(uart_mode_pkg::IDX_CMC, 8'h15);
		rd(uart_mode_pkg::IDX_PTR);
		chk(q, 32'h15);
		rd(6'h3f);
		chk(q, 32'h0);
		wr(uart_mode_pkg::IDX_ENABLE, 8'h10);
		rd(uart_mode_pkg::IDX_PTR);
		chk(q, {24'h0, uart_mode_pkg::RST_MODE1});
		wr(uart_mode_pkg::IDX_DIV_LO, 8'h10);
		wr(uart_mode_pkg::IDX_DIV_HI, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_normal;
		wr(uart_mode_pkg::IDX_ENABLE, 8'h01);
		i_peer.send(8'ha5);
		wait_rx;
		rd(uart_mode_pkg::IDX_RXDATA);
		chk(q, 32'ha5);
		chk(i_peer.got_count, 32'h0);
		$display("test normal done");
	endtask
	task automatic t_echo;
		wr(uart_mode_pkg::IDX_CMC, 8'h40);
		i_peer.send(8'h3c);
		wait_echo(1);
		chk(i_peer.got_count, 32'h1);
		chk({24'h0, i_peer.got_r}, 32'h3c);
		rd(uart_mode_pkg::IDX_STATUS);
		chk(q & 32'h0d, 32'h01);
		rd(uart_mode_pkg::IDX_RXDATA);
		chk(q, 32'h3c);
		// Must be dropped: if kept, the local loop test would see it first
		wr(uart_mode_pkg::IDX_TXDATA, 8'h77);
		$display("test echo done");
	endtask
	task automatic t_local;
		wr(uart_mode_pkg::IDX_CMC, 8'h80);
		wr(uart_mode_pkg::IDX_ENABLE, 8'h02);
		wr(uart_mode_pkg::IDX_TXDATA, 8'h96);
		wait_rx;
		rd(uart_mode_pkg::IDX_RXDATA);
		chk(q, 32'h96);
		chk(i_peer.got_count, 32'h1);
		$display("test local done");
	endtask
	task automatic t_remote;
		wr(uart_mode_pkg::IDX_CMC, 8'hc0);
		wr(uart_mode_pkg::IDX_ENABLE, 8'h01);
		i_peer.send(8'h5a);
		wait_echo(2);
		chk({24'h0, i_peer.got_r}, 32'h5a);
		rd(uart_mode_pkg::IDX_STATUS);
		chk(q & 32'hf1, 32'h0);
		rd(uart_mode_pkg::IDX_RXDATA);
		chk(q, 32'h96);
		$display("test remote done");
	endtask
	task automatic t_break;
		i_peer.hold_line(1'b0);
		repeat (192) @(posedge clk_i);
		chk({31'h0, txd_o}, 32'h0);
		i_peer.hold_line(1'b1);
		repeat (16) @(posedge clk_i);
		chk({31'h0, txd_o}, 32'h1);
		i_peer.send(8'hc3);
		wait_echo(3);
		chk({24'h0, i_peer.got_r}, 32'hc3);
		$display("test break done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		test_done;
	end
	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h0;
		wb_sel_i = 4'h1;
		wb_dat_i = 32'h0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_normal;
		t_echo;
		t_local;
		t_remote;
		t_break;
		test_done;
	end
endmodule
